/* can_msg_pkg.sv */
`default_nettype none
package can_msg_pkg;
    // ----------------------------------------
    // Window and slot layout
    // ----------------------------------------
    localparam int WINDOW_BYTES = 128;
    localparam int SLOT_BYTES = 16;
    localparam int STRUCT_BYTES = 13;
    localparam int SLOT_COUNT = 4;
    localparam int ADDR_W = 7;
    localparam logic [2:0] RX_SLOT_NIBBLE = 3'h4;
    localparam logic [2:0] TX0_SLOT_NIBBLE = 3'h5;
    localparam logic [2:0] TX2_SLOT_NIBBLE = 3'h7;
    localparam logic [1:0] RX_SLOT_INDEX = 2'h0;
    // ----------------------------------------
    // Byte offsets within a slot
    // ----------------------------------------
    localparam logic [3:0] ID_BYTE_0 = 4'h0;
    localparam logic [3:0] ID_BYTE_1 = 4'h1;
    localparam logic [3:0] ID_BYTE_2 = 4'h2;
    localparam logic [3:0] ID_BYTE_3 = 4'h3;
    localparam logic [3:0] PAYLOAD_BYTE_0 = 4'h4;
    localparam logic [3:0] LENGTH_BYTE = 4'hC;
    localparam logic [3:0] PRIORITY_BYTE = 4'hD;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int EXT_SRR_BIT = 4;
    localparam int IDE_BIT = 3;
    localparam int EXT_RTR_BIT = 0;
    localparam int STD_RTR_BIT = 4;
    localparam logic [5:0] STD_ARB_BITS = 6'h0D;
    localparam logic [5:0] EXT_ARB_BITS = 6'h20;
    localparam logic [3:0] MAX_PAYLOAD = 4'h8;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // ----------------------------------------
    // Transmit sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ARB = 2'b01,
        TX_LOADED = 2'b11
    } tx_state_t;
endpackage
`default_nettype wire

/* tx_priority_pick.sv */
`timescale 1ns/1ns
`default_nettype none
module tx_priority_pick
    import can_msg_pkg::*;
(
    input wire logic [2:0] pending,
    input wire logic [7:0] prio_0,
    input wire logic [7:0] prio_1,
    input wire logic [7:0] prio_2,
    output logic win_valid,
    output logic [1:0] win_index
);
    // ----------------------------------------
    // Lowest value wins, lower index on a tie
    // ----------------------------------------
    function automatic logic beats(input logic a_ok, input logic [7:0] a, input logic b_ok, input logic [7:0] b);
        beats = a_ok && (!b_ok || a <= b);
    endfunction

    always_comb
    begin
        win_valid = |pending;
        if (beats(pending[0], prio_0, pending[1], prio_1) && beats(pending[0], prio_0, pending[2], prio_2))
        begin
            win_index = 2'h0;
        end
        else if (beats(pending[1], prio_1, pending[2], prio_2))
        begin
            win_index = 2'h1;
        end
        else
        begin
            win_index = 2'h2;
        end
    end
endmodule // tx_priority_pick
`default_nettype wire

/* can_message_buffer_map.sv */
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Block answers a 128-byte window; only message slots return data.
// - Background receive buffer readable only while test mode is high.
// - Each slot is 16 bytes, 13 used in receive and 14 in transmit; receive and transmit share layout.
// - Slot nibble 4 is foreground receive, 5 to 7 transmit slots 0 to 2.
// - Bytes 0-3 identifier, 4-B payload, C length, D transmit priority.
// - Buffer contents carry no defined value after reset; this block clears them to zero.
// - Foreground receive slot reads while test mode is low; writes to it are dropped.
// - Transmit slots accept reads and writes at any time.
// - Extended identifier bits, SRR, IDE and RTR in fixed byte positions.
// - Both 11-bit and 29-bit identifiers are supported.
// - Arbitration field is shifted out most significant bit first.
// - Smallest identifier value has the highest bus priority.
// - Received SRR is stored exactly as sampled.
// - IDE zero standard, one extended; loaded on receive, selects format.
// - RTR zero data, one remote; stored on receive, sent on transmit.
// - Length low nibble gives byte count in binary, 0 to 8.
// - Remote frame sends its length code as written but no data.
// - Only as many payload bytes as the length code are moved.
// - Lowest priority byte among pending slots wins; lower index on tie.
module can_message_buffer_map
    import can_msg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [6:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic test_mode,
    input wire logic rx_store,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_srr,
    input wire logic rx_rtr,
    input wire logic [3:0] rx_dlc,
    input wire logic [63:0] rx_payload,
    input wire logic rx_commit,
    input wire logic [2:0] transmit_slot_empty_flag,
    input wire logic tx_start,
    input wire logic tx_shift,
    input wire logic tx_byte_req,
    input wire logic [2:0] tx_byte_sel,
    input wire logic tx_release,
    output logic tx_active,
    output logic [1:0] tx_slot,
    output logic tx_arb_bit,
    output logic tx_arb_done,
    output logic tx_ide,
    output logic tx_rtr,
    output logic [3:0] tx_dlc,
    output logic [3:0] tx_byte_count,
    output logic [7:0] tx_byte
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [3:0][13:0][7:0] slots;
        logic [12:0][7:0] background;
        logic [7:0] rdata;
        tx_state_t tx_state;
        logic [1:0] tx_slot;
        logic [31:0] arb;
        logic [5:0] arb_left;
        logic arb_bit;
        logic tx_ide;
        logic tx_rtr;
        logic [3:0] tx_dlc;
        logic [3:0] tx_count;
        logic [7:0] tx_byte;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic win_valid;
    logic [1:0] win_index;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] pack_id(input logic [28:0] id, input logic ide, input logic srr,
                                            input logic rtr);
        if (ide)
        begin
            pack_id = {id[28:21], id[20:18], srr, 1'b1, id[17:15], id[14:7], id[6:0], rtr};
        end
        else
        begin
            pack_id = {id[10:3], id[2:0], rtr, 1'b0, 3'h0, 16'h0000};
        end
    endfunction

    function automatic logic [3:0] byte_count(input logic [3:0] dlc, input logic rtr);
        if (rtr)
        begin
            byte_count = 4'h0;
        end
        else if (dlc > MAX_PAYLOAD)
        begin
            byte_count = MAX_PAYLOAD;
        end
        else
        begin
            byte_count = dlc;
        end
    endfunction

    function automatic logic frame_is_remote(input logic [7:0] b1, input logic [7:0] b3);
        frame_is_remote = b1[IDE_BIT] ? b3[EXT_RTR_BIT] : b1[STD_RTR_BIT];
    endfunction

    // ----------------------------------------
    // Transmit slot selection
    // ----------------------------------------
    tx_priority_pick u_pick (
        .pending(~transmit_slot_empty_flag),
        .prio_0(state_reg.slots[1][PRIORITY_BYTE]),
        .prio_1(state_reg.slots[2][PRIORITY_BYTE]),
        .prio_2(state_reg.slots[3][PRIORITY_BYTE]),
        .win_valid(win_valid),
        .win_index(win_index)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic [1:0] slot_idx;
        logic [3:0] byte_idx;
        logic [1:0] src;
        logic [3:0] cnt;
        logic [31:0] packed_id;
        slot_idx = 2'h0;
        byte_idx = 4'h0;
        src = 2'h0;
        cnt = 4'h0;
        packed_id = 32'h0000_0000;
        state_next = state_reg;
        slot_idx = cpu_addr[5:4];
        byte_idx = cpu_addr[3:0];

        // CPU reads
        if (cpu_rd)
        begin
            state_next.rdata = BYTE_RESET;
            if (cpu_addr[6] && byte_idx < LENGTH_BYTE + 4'h1)
            begin
                if (slot_idx == RX_SLOT_INDEX && test_mode)
                begin
                    state_next.rdata = state_reg.background[byte_idx];
                end
                else
                begin
                    state_next.rdata = state_reg.slots[slot_idx][byte_idx];
                end
            end
            else if (cpu_addr[6] && byte_idx == PRIORITY_BYTE && slot_idx != RX_SLOT_INDEX)
            begin
                state_next.rdata = state_reg.slots[slot_idx][byte_idx];
            end
        end

        // CPU writes: transmit slots only
        if (cpu_wr && cpu_addr[6] && slot_idx != RX_SLOT_INDEX && byte_idx <= PRIORITY_BYTE)
        begin
            state_next.slots[slot_idx][byte_idx] = cpu_wdata;
        end

        // Receive into background buffer
        if (rx_store)
        begin
            packed_id = pack_id(rx_id, rx_ide, rx_srr, rx_rtr);
            state_next.background[ID_BYTE_0] = packed_id[31:24];
            state_next.background[ID_BYTE_1] = packed_id[23:16];
            state_next.background[ID_BYTE_2] = packed_id[15:8];
            state_next.background[ID_BYTE_3] = packed_id[7:0];
            state_next.background[LENGTH_BYTE] = {4'h0, rx_dlc};
            cnt = byte_count(rx_dlc, rx_rtr);
            for (int i = 0; i < 8; i++)
            begin
                if (4'(i) < cnt)
                begin
                    state_next.background[PAYLOAD_BYTE_0 + 4'(i)] = rx_payload[63 - 8 * i -: 8];
                end
            end
        end

        // Hand completed frame to foreground
        if (rx_commit)
        begin
            for (int i = 0; i < STRUCT_BYTES; i++)
            begin
                state_next.slots[RX_SLOT_INDEX][i] = state_reg.background[i];
            end
        end

        // Transmit sequencer
        src = state_reg.tx_slot + 2'h1;
        unique case (state_reg.tx_state)
            TX_IDLE:
            begin
                if (tx_start && win_valid)
                begin
                    src = win_index + 2'h1;
                    state_next.tx_slot = win_index;
                    state_next.tx_state = TX_ARB;
                    state_next.arb = {state_reg.slots[src][ID_BYTE_0], state_reg.slots[src][ID_BYTE_1],
                                      state_reg.slots[src][ID_BYTE_2], state_reg.slots[src][ID_BYTE_3]};
                    state_next.tx_ide = state_reg.slots[src][ID_BYTE_1][IDE_BIT];
                    state_next.arb_left = state_next.tx_ide ? EXT_ARB_BITS : STD_ARB_BITS;
                    state_next.tx_rtr = frame_is_remote(state_reg.slots[src][ID_BYTE_1],
                                                        state_reg.slots[src][ID_BYTE_3]);
                    state_next.tx_dlc = state_reg.slots[src][LENGTH_BYTE][3:0];
                    state_next.tx_count = byte_count(state_next.tx_dlc, state_next.tx_rtr);
                end
            end
            TX_ARB:
            begin
                if (tx_shift)
                begin
                    state_next.arb_bit = state_reg.arb[31];
                    state_next.arb = {state_reg.arb[30:0], 1'b0};
                    state_next.arb_left = state_reg.arb_left - 6'h01;
                    if (state_reg.arb_left == 6'h01)
                    begin
                        state_next.tx_state = TX_LOADED;
                    end
                end
                if (tx_release)
                begin
                    state_next.tx_state = TX_IDLE;
                end
            end
            TX_LOADED:
            begin
                if (tx_release)
                begin
                    state_next.tx_state = TX_IDLE;
                end
            end
            default:
            begin
                state_next.tx_state = TX_IDLE;
            end
        endcase

        // Payload byte fetch, limited to the byte count
        if (tx_byte_req && state_reg.tx_state != TX_IDLE)
        begin
            state_next.tx_byte = BYTE_RESET;
            if ({1'b0, tx_byte_sel} < state_reg.tx_count)
            begin
                state_next.tx_byte = state_reg.slots[src][PAYLOAD_BYTE_0 + {1'b0, tx_byte_sel}];
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign cpu_rdata = state_reg.rdata;
    assign tx_active = state_reg.tx_state[0];
    assign tx_slot = state_reg.tx_slot;
    assign tx_arb_bit = state_reg.arb_bit;
    assign tx_arb_done = state_reg.tx_state[1];
    assign tx_ide = state_reg.tx_ide;
    assign tx_rtr = state_reg.tx_rtr;
    assign tx_dlc = state_reg.tx_dlc;
    assign tx_byte_count = state_reg.tx_count;
    assign tx_byte = state_reg.tx_byte;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    rx_write_dropped_a: assert property (
        cpu_wr && cpu_addr[6:4] == RX_SLOT_NIBBLE && !rx_commit |=> $stable(state_reg.slots[0]))
        else $error("write changed foreground receive slot");

    tx_write_taken_a: assert property (
        cpu_wr && cpu_addr[6] && cpu_addr[5:4] != 2'h0 && cpu_addr[3:0] == ID_BYTE_2
        |=> state_reg.slots[$past(cpu_addr[5:4])][ID_BYTE_2] == $past(cpu_wdata))
        else $error("transmit slot write lost");

    outside_reads_zero_a: assert property (
        cpu_rd && !cpu_addr[6] |=> cpu_rdata == 8'h00)
        else $error("read outside message storage not zero");

    background_hidden_a: assert property (
        cpu_rd && cpu_addr[6:4] == RX_SLOT_NIBBLE && !test_mode && cpu_addr[3:0] == ID_BYTE_0 && !rx_commit
        |=> cpu_rdata == state_reg.slots[0][ID_BYTE_0])
        else $error("background buffer visible outside test mode");

    tie_low_index_a: assert property (
        state_reg.tx_state == TX_IDLE && tx_start && transmit_slot_empty_flag == 3'b000
        && state_reg.slots[1][PRIORITY_BYTE] == state_reg.slots[2][PRIORITY_BYTE]
        && state_reg.slots[1][PRIORITY_BYTE] <= state_reg.slots[3][PRIORITY_BYTE]
        |=> tx_slot == 2'h0 && tx_active)
        else $error("priority tie not won by lower index");

    byte_limit_a: assert property (
        tx_active |-> tx_byte_count <= MAX_PAYLOAD && (!tx_rtr || tx_byte_count == 4'h0))
        else $error("transmit byte count out of range");

    msb_first_a: assert property (
        state_reg.tx_state == TX_ARB && tx_shift && !tx_release
        |=> tx_arb_bit == $past(state_reg.arb[31]) && state_reg.arb_left == $past(state_reg.arb_left) - 6'h01)
        else $error("arbitration bit order wrong");

    ext_receive_pack_a: assert property (
        rx_store && rx_ide
        |=> state_reg.background[ID_BYTE_1][IDE_BIT] && state_reg.background[ID_BYTE_1][EXT_SRR_BIT] == $past(rx_srr)
            && state_reg.background[ID_BYTE_0] == $past(rx_id[28:21]))
        else $error("extended identifier stored wrongly");

    std_arb_len_a: assert property (
        state_reg.tx_state == TX_IDLE && tx_start && win_valid && !state_reg.slots[win_index + 2'h1][ID_BYTE_1][IDE_BIT]
        |=> state_reg.arb_left == STD_ARB_BITS)
        else $error("standard arbitration length wrong");

    rx_commit_c: cover property (rx_store ##1 rx_commit);
    tx_full_c: cover property (tx_start && win_valid ##1 tx_active ##[1:40] tx_arb_done);
    test_read_c: cover property (cpu_rd && test_mode && cpu_addr[6:4] == RX_SLOT_NIBBLE);
endmodule // can_message_buffer_map
`default_nettype wire

/* can_node_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Far-side bus node: feeds frames, runs transmit sequencing
// ----------------------------------------
module can_node_model
    import can_msg_pkg::*;
(
    input wire logic sys_clk,
    output logic rx_store,
    output logic [28:0] rx_id,
    output logic rx_ide,
    output logic rx_srr,
    output logic rx_rtr,
    output logic [3:0] rx_dlc,
    output logic [63:0] rx_payload,
    output logic rx_commit,
    output logic tx_start,
    output logic tx_shift,
    output logic tx_byte_req,
    output logic [2:0] tx_byte_sel,
    output logic tx_release,
    input wire logic tx_arb_bit,
    input wire logic tx_arb_done,
    input wire logic [7:0] tx_byte
);
    initial
    begin
        {rx_store, rx_commit, tx_start, tx_shift, tx_byte_req, tx_release} = 6'h00;
        {rx_id, rx_ide, rx_srr, rx_rtr, rx_dlc, rx_payload} = '0;
        tx_byte_sel = 3'h0;
    end

    task automatic store(input logic [28:0] id, input logic ide, input logic srr, input logic rtr,
                         input logic [3:0] dlc, input logic [63:0] pl);
        @(posedge sys_clk) #1 {rx_id, rx_ide, rx_srr, rx_rtr, rx_dlc, rx_payload} = {id, ide, srr, rtr, dlc, pl};
        rx_store = 1'b1;
        @(posedge sys_clk) #1 rx_store = 1'b0;
        // Released lines show the inverse of the last value
        {rx_id, rx_ide, rx_srr, rx_rtr, rx_dlc, rx_payload} = ~{rx_id, rx_ide, rx_srr, rx_rtr, rx_dlc, rx_payload};
    endtask

    task automatic commit();
        @(posedge sys_clk) #1 rx_commit = 1'b1;
        @(posedge sys_clk) #1 rx_commit = 1'b0;
    endtask

    task automatic start();
        @(posedge sys_clk) #1 tx_start = 1'b1;
        @(posedge sys_clk) #1 tx_start = 1'b0;
    endtask

    task automatic arb(input int n, output logic [31:0] bits);
        bits = '0;
        @(posedge sys_clk) #1 tx_shift = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk) #1 bits = {bits[30:0], tx_arb_bit};
        end
        tx_shift = 1'b0;
        for (int i = 0; i < 4 && tx_arb_done !== 1'b1; i++)
        begin
            @(posedge sys_clk) #1;
        end
    endtask

    task automatic fetch(input logic [2:0] sel, output logic [7:0] d);
        @(posedge sys_clk) #1 tx_byte_sel = sel;
        tx_byte_req = 1'b1;
        @(posedge sys_clk) #1 tx_byte_req = 1'b0;
        d = tx_byte;
        tx_byte_sel = ~sel;
    endtask

    task automatic release_tx();
        @(posedge sys_clk) #1 tx_release = 1'b1;
        @(posedge sys_clk) #1 tx_release = 1'b0;
    endtask
endmodule // can_node_model
`default_nettype wire

/* can_message_buffer_map_test.sv */
`timescale 1ns/1ns
`default_nettype none
module can_message_buffer_map_test;
    import can_msg_pkg::*;
    logic sys_clk, resetn, cpu_wr, cpu_rd, test_mode, tx_active, tx_arb_bit, tx_arb_done, tx_ide, tx_rtr;
    logic rx_store, rx_ide, rx_srr, rx_rtr, rx_commit, tx_start, tx_shift, tx_byte_req, tx_release;
    logic [6:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata, tx_byte;
    logic [28:0] rx_id;
    logic [3:0] rx_dlc, tx_dlc, tx_byte_count;
    logic [63:0] rx_payload;
    logic [2:0] transmit_slot_empty_flag, tx_byte_sel;
    logic [1:0] tx_slot;
    logic [7:0] exp_bg [13];
    int n_fail = 0;
    int checks = 0;

    can_message_buffer_map DUT (.sys_clk(sys_clk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .test_mode(test_mode),
        .rx_store(rx_store), .rx_id(rx_id), .rx_ide(rx_ide), .rx_srr(rx_srr), .rx_rtr(rx_rtr),
        .rx_dlc(rx_dlc), .rx_payload(rx_payload), .rx_commit(rx_commit),
        .transmit_slot_empty_flag(transmit_slot_empty_flag), .tx_start(tx_start), .tx_shift(tx_shift),
        .tx_byte_req(tx_byte_req), .tx_byte_sel(tx_byte_sel), .tx_release(tx_release), .tx_active(tx_active),
        .tx_slot(tx_slot), .tx_arb_bit(tx_arb_bit), .tx_arb_done(tx_arb_done), .tx_ide(tx_ide),
        .tx_rtr(tx_rtr), .tx_dlc(tx_dlc), .tx_byte_count(tx_byte_count), .tx_byte(tx_byte));

    can_node_model node (.sys_clk(sys_clk), .rx_store(rx_store), .rx_id(rx_id), .rx_ide(rx_ide),
        .rx_srr(rx_srr), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_payload(rx_payload), .rx_commit(rx_commit),
        .tx_start(tx_start), .tx_shift(tx_shift), .tx_byte_req(tx_byte_req), .tx_byte_sel(tx_byte_sel),
        .tx_release(tx_release), .tx_arb_bit(tx_arb_bit), .tx_arb_done(tx_arb_done), .tx_byte(tx_byte));

    // ----------------------------------------
    // Bus cycles and compares
    // ----------------------------------------
    task automatic rd(input int a, output logic [7:0] d);
        @(posedge sys_clk) #1 cpu_addr = 7'(a);
        cpu_rd = 1'b1;
        @(posedge sys_clk) #1 cpu_rd = 1'b0;
        d = cpu_rdata;
    endtask

    task automatic wr(input int a, input logic [7:0] d);
        @(posedge sys_clk) #1 cpu_addr = 7'(a);
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(posedge sys_clk) #1 cpu_wr = 1'b0;
        cpu_wdata = ~d;
    endtask

    task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    function automatic logic [31:0] id_bytes(input logic [28:0] id, input logic ide, input logic srr,
                                             input logic rtr);
        if (ide)
            return {id[28:21], id[20:18], srr, 1'b1, id[17:15], id[14:7], id[6:0], rtr};
        return {id[10:3], id[2:0], rtr, 1'b0, 3'b000, 16'h0000};
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_map();
        logic [7:0] d;
        for (int a = 80; a < 128; a++)
            if (a % 16 < 14)
                wr(a, 8'(a + 3));
        for (int a = 80; a < 128; a++)
        begin
            rd(a, d);
            check_byte("transmit slot byte", (a % 16 < 14) ? 8'(a + 3) : 8'h00, d);
        end
        wr(8'h5E, 8'hA5);
        rd(8'h5E, d);
        check_byte("unused byte", 8'h00, d);
        rd(8'h00, d);
        check_byte("low window", 8'h00, d);
        rd(8'h4D, d);
        check_byte("receive priority byte", 8'h00, d);
        $display("test t_map done");
    endtask

    task automatic rx_case(input logic [28:0] id, input logic ide, input logic srr, input logic rtr,
                           input logic [3:0] dlc, input logic [63:0] pl);
        logic [7:0] old0;
        logic [7:0] d;
        logic [31:0] w;
        int n;
        old0 = exp_bg[0];
        w = id_bytes(id, ide, srr, rtr);
        for (int i = 0; i < 4; i++)
            exp_bg[i] = w[31 - 8 * i -: 8];
        n = rtr ? 0 : (dlc > 8 ? 8 : int'(dlc));
        for (int i = 0; i < n; i++)
            exp_bg[4 + i] = pl[63 - 8 * i -: 8];
        exp_bg[12] = {4'h0, dlc};
        node.store(id, ide, srr, rtr, dlc, pl);
        test_mode = 1'b1;
        rd(8'h40, d);
        check_byte("background byte 0", exp_bg[0], d);
        test_mode = 1'b0;
        rd(8'h40, d);
        check_byte("foreground byte 0", old0, d);
        node.commit();
        wr(8'h40, ~exp_bg[0]);
        for (int i = 0; i < 13; i++)
        begin
            rd(64 + i, d);
            check_byte("receive slot byte", exp_bg[i], d);
        end
        $display("test rx_case done");
    endtask

    task automatic write_slot(input int s, input logic [31:0] w, input logic [3:0] dlc, input logic [7:0] prio);
        transmit_slot_empty_flag = 3'b111;
        for (int b = 0; b < 4; b++)
            wr(80 + 16 * s + b, w[31 - 8 * b -: 8]);
        for (int b = 0; b < 8; b++)
            wr(84 + 16 * s + b, 8'(16 * s + b));
        wr(92 + 16 * s, {4'h0, dlc});
        wr(93 + 16 * s, prio);
    endtask

    task automatic tx_case(input logic [2:0] empty, input int s, input logic [31:0] w, input int nbits,
                           input logic [9:0] fmt, input logic [2:0] sel);
        logic [31:0] bits;
        logic [7:0] d;
        transmit_slot_empty_flag = empty;
        node.start();
        check_word("tx_slot", 32'(s), {30'h0, tx_slot});
        check_word("tx format", {22'h0, fmt}, {22'h0, tx_ide, tx_rtr, tx_dlc, tx_byte_count});
        node.arb(nbits, bits);
        check_word("arbitration bits", w >> (32 - nbits), bits);
        check_word("arbitration done", 32'h1, {31'h0, tx_arb_done});
        node.fetch(sel, d);
        check_byte("tx byte", (sel < fmt[3:0]) ? 8'(16 * s + sel) : 8'h00, d);
        node.release_tx();
        for (int i = 0; i < 4 && tx_active !== 1'b0; i++)
            @(posedge sys_clk) #1;
        check_word("tx_active", 32'h0, {31'h0, tx_active});
        transmit_slot_empty_flag = 3'b111;
        $display("test tx_case done");
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #200000;
        n_fail++;
        final_report();
    end

    initial
    begin
        {resetn, cpu_wr, cpu_rd, test_mode} = 4'h0;
        cpu_addr = 7'h00;
        cpu_wdata = 8'h00;
        transmit_slot_empty_flag = 3'b111;
        for (int i = 0; i < 13; i++)
            exp_bg[i] = 8'h00;
        repeat (4) @(posedge sys_clk);
        #1 resetn = 1'b1;
        t_map();
        rx_case(29'h000005A3, 1'b0, 1'b0, 1'b0, 4'h8, 64'hEEEEEEEEEEEEEEEE);
        rx_case(29'h15A3C96E, 1'b1, 1'b1, 1'b0, 4'h3, 64'h1122334455667788);
        rx_case(29'h000003C5, 1'b0, 1'b0, 1'b1, 4'h5, 64'h0123456789ABCDEF);
        write_slot(0, id_bytes(29'h0ABCDE12, 1'b1, 1'b1, 1'b0), 4'hB, 8'h05);
        write_slot(1, id_bytes(29'h000003C5, 1'b0, 1'b0, 1'b1), 4'h5, 8'h03);
        write_slot(2, id_bytes(29'h00000123, 1'b0, 1'b0, 1'b0), 4'h2, 8'h03);
        tx_case(3'b000, 1, id_bytes(29'h000003C5, 1'b0, 1'b0, 1'b1), 13, {2'b01, 4'h5, 4'h0}, 3'h0);
        tx_case(3'b110, 0, id_bytes(29'h0ABCDE12, 1'b1, 1'b1, 1'b0), 32, {2'b10, 4'hB, 4'h8}, 3'h7);
        tx_case(3'b010, 2, id_bytes(29'h00000123, 1'b0, 1'b0, 1'b0), 13, {2'b00, 4'h2, 4'h2}, 3'h2);
        wr(8'h5D, 8'h03);
        tx_case(3'b000, 0, id_bytes(29'h0ABCDE12, 1'b1, 1'b1, 1'b0), 32, {2'b10, 4'hB, 4'h8}, 3'h3);
        final_report();
    end
endmodule // can_message_buffer_map_test
`default_nettype wire
